/* File: hw/adcpp_pkg.sv */
/*
  Shared constants for the converter parallel port: widths, full scale, mode pin codes,
  offset reset value and timing counts.
  Assumes a single 40 MHz clock shared by both ends.
*/
package adcpp_pkg;
  localparam int RAW_WIDTH = 12;
  localparam int BUS_WIDTH = 13;
  localparam int OFS_WIDTH = 10;
  localparam logic [12:0] FULL_SCALE = 13'h0_FFF;
  localparam logic [9:0] OFS_RESET = 10'h0_00;
  localparam logic [1:0] MODE_EARLY = 2'h1;
  localparam logic [1:0] MODE_DEFERRED = 2'h2;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 300;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_TIME_NS = 50;
  localparam int QUIET_CYCLES = (QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES = 2;
endpackage : adcpp_pkg

/* File: hw/adcpp_if.sv */
/*
  Pin-level carrier between converter port and host.
  Resolves the shared data bus here from the two enables, the device enable first.
*/
`timescale 1ns/1ps
interface adcpp_if;
  logic sample_trigger_n;
  logic busy_n;
  logic chip_select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic [12:0] dev_data_out;
  logic dev_data_oe;
  logic [12:0] host_data_out;
  logic host_data_oe;
  logic [12:0] data_bus;
  assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 13'h0_000);
  modport device (input sample_trigger_n, input chip_select_n, input read_strobe_n, input write_strobe_n,
    input host_data_out, output busy_n, output dev_data_out, output dev_data_oe);
  modport host (output sample_trigger_n, output chip_select_n, output read_strobe_n, output write_strobe_n,
    output host_data_out, output host_data_oe, input busy_n, input data_bus);
endinterface : adcpp_if

/* File: hw/adcpp_device.sv */
/*
  Converter digital side: conversion timing, offset add, clamp or overrange
  coding, output register update modes and the parallel read/write port.
  Assumes the raw result is presented on raw_result while busy is low.
*/
`timescale 1ns/1ps
module adcpp_device (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic saturate_select,
  input wire logic [1:0] mode_pins,
  input wire logic [11:0] raw_result,
  output logic mode_invalid,
  adcpp_if.device port
);
  typedef enum logic [0:0] {ADCPP_IDLE, ADCPP_CONV} adcpp_state_type;
  adcpp_state_type state;
  adcpp_state_type next_state;
  // Strobe pins in sync order: trigger, chip select, read, write
  wire [3:0] strobe_pin = {port.write_strobe_n, port.read_strobe_n, port.chip_select_n, port.sample_trigger_n};
  wire [3:0] strobe_s2;
  wire [3:0] strobe_s3;
  logic [1:0] mode_s1;
  logic [1:0] mode_s2;
  logic sat_s1;
  logic sat_s2;
  logic [12:0] wdata_s1;
  logic [12:0] wdata_s2;
  logic [9:0] offset;
  logic [12:0] out_reg;
  logic [12:0] pending;
  logic [4:0] conv_cnt;
  logic busy_n;
  logic [12:0] dev_data_out;
  logic dev_data_oe;

  // Edge test shared by the trigger and write strobe detectors
  function automatic logic edge_seen(input logic older, input logic newer, input logic rising);
    edge_seen = rising ? (!older && newer) : (older && !newer);
  endfunction : edge_seen

  // Every strobe pin passes two flops; the third tap gives the edge detectors their history and the offset load its held chip select
  generate
    for (genvar g = 0; g < 4; g++) begin : g_strobe_sync
      logic [2:0] taps;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          taps <= 3'h7;
        end else begin
          taps <= {taps[1:0], strobe_pin[g]};
        end
      end
      assign strobe_s2[g] = taps[1];
      assign strobe_s3[g] = taps[2];
    end
  endgenerate

  // Idle level of every strobe is high, so the reset value of the taps gives no false edge
  wire trig_fall = edge_seen(strobe_s3[0], strobe_s2[0], 1'b0);
  wire wr_rise = edge_seen(strobe_s3[3], strobe_s2[3], 1'b1);
  wire cs_active = ~strobe_s2[1];
  wire cs_held = ~strobe_s3[1];
  wire rd_active = ~strobe_s2[2];
  wire trig_taken = trig_fall && (state == ADCPP_IDLE);
  wire conv_done = (state == ADCPP_CONV) && (conv_cnt == 5'(adcpp_pkg::CONV_CYCLES - 1));
  wire ofs_load = wr_rise && cs_held && (state == ADCPP_IDLE);
  wire mode_early = (mode_s2 == adcpp_pkg::MODE_EARLY);
  wire mode_deferred = (mode_s2 == adcpp_pkg::MODE_DEFERRED);
  wire mode_bad = !(mode_early | mode_deferred);

  // One bit of headroom: raw plus the largest offset passes the top of a 13-bit signed value
  wire signed [13:0] sum = $signed({2'b00, raw_result}) + $signed({{4{offset[9]}}, offset});
  wire below = sum[13];
  wire above = !sum[13] && (sum > $signed({1'b0, adcpp_pkg::FULL_SCALE}));
  wire out_of_range = below | above;
  wire [11:0] clamped = below ? 12'h000 : (above ? 12'hFFF : sum[11:0]);
  // Unclamped, the low 13 bits already carry the coding: negative sums set bits 12 and 11,
  // sums past full scale set bit 12 with bit 11 clear, in-range sums leave bit 12 clear
  wire [12:0] wide_word = sum[12:0];
  wire [12:0] result_word = sat_s2 ? {out_of_range, clamped} : wide_word;
  wire next_oe = cs_active & rd_active;

  always_comb begin
    next_state = state;
    unique case (state)
      ADCPP_IDLE: begin
        if (trig_taken) begin
          next_state = ADCPP_CONV;
        end
      end
      ADCPP_CONV: begin
        if (conv_done) begin
          next_state = ADCPP_IDLE;
        end
      end
    endcase
  end

  // Level pins and the write word pass two flops too; the mode reads as early until seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1 <= adcpp_pkg::MODE_EARLY;
      mode_s2 <= adcpp_pkg::MODE_EARLY;
      sat_s1 <= 1'b0;
      sat_s2 <= 1'b0;
      wdata_s1 <= 13'h0000;
      wdata_s2 <= 13'h0000;
    end else begin
      mode_s1 <= mode_pins;
      mode_s2 <= mode_s1;
      sat_s1 <= saturate_select;
      sat_s2 <= sat_s1;
      wdata_s1 <= port.host_data_out;
      wdata_s2 <= wdata_s1;
    end
  end

  // Conversion length is a fixed count; triggers during a conversion are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ADCPP_IDLE;
      conv_cnt <= 5'h00;
      busy_n <= 1'b1;
    end else begin
      state <= next_state;
      if (state == ADCPP_CONV && !conv_done) begin
        conv_cnt <= conv_cnt + 5'h01;
      end else begin
        conv_cnt <= 5'h00;
      end
      if (trig_taken) begin
        busy_n <= 1'b0;
      end else if (conv_done) begin
        busy_n <= 1'b1;
      end
    end
  end

  // A write inside a conversion is dropped so the sum stays steady until the result is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset <= adcpp_pkg::OFS_RESET;
    end else if (ofs_load) begin
      offset <= wdata_s2[9:0];
    end
  end

  // Deferred mode shows each result one trigger late; pending keeps it until then
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 13'h0000;
      out_reg <= 13'h0000;
    end else begin
      if (conv_done) begin
        pending <= result_word;
      end
      if (conv_done && mode_early) begin
        out_reg <= result_word;
      end else if (trig_taken && mode_deferred) begin
        out_reg <= pending;
      end
    end
  end

  // Pins come from flops so the bus and its enable never glitch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_data_out <= 13'h0000;
      dev_data_oe <= 1'b0;
    end else begin
      dev_data_out <= out_reg;
      dev_data_oe <= next_oe;
    end
  end

  // Invalid pin codes load nothing into the output register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_invalid <= 1'b0;
    end else begin
      mode_invalid <= mode_bad;
    end
  end

  assign port.busy_n = busy_n;
  assign port.dev_data_out = dev_data_out;
  assign port.dev_data_oe = dev_data_oe;
endmodule : adcpp_device

/* File: hw/adcpp_host.sv */
/*
  Host end: issues triggers, reads results after busy rises, writes offsets.
  Assumes the user side keeps requests one at a time and offsets in range.
*/
`timescale 1ns/1ps
module adcpp_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start_conv,
  input wire logic write_req,
  input wire logic [9:0] write_offset,
  output logic idle,
  output logic result_valid,
  output logic [12:0] result_data,
  adcpp_if.host port
);
  typedef enum logic [2:0] {ADCPPH_IDLE, ADCPPH_TRIG, ADCPPH_WAIT, ADCPPH_READ, ADCPPH_WRITE,
    ADCPPH_QUIET} adcpph_state_type;
  adcpph_state_type state;
  logic [1:0] busy_sync;
  logic [4:0] cnt;
  logic seen_low;
  logic trig_n;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [12:0] wdata;
  logic w_oe;
  wire busy_rose = seen_low & busy_sync[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_sync <= 2'h3;
    else busy_sync <= {busy_sync[0], port.busy_n};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ADCPPH_IDLE;
      cnt <= 5'h0_0;
      seen_low <= 1'b0;
      trig_n <= 1'b1;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      wdata <= 13'h0_000;
      w_oe <= 1'b0;
      idle <= 1'b0;
      result_valid <= 1'b0;
      result_data <= 13'h0_000;
    end else begin
      result_valid <= 1'b0;
      idle <= (state == ADCPPH_IDLE);
      unique case (state)
        ADCPPH_IDLE: if (start_conv) begin
          trig_n <= 1'b0;
          seen_low <= 1'b0;
          cnt <= 5'h0_0;
          state <= ADCPPH_TRIG;
          // Drop idle at once so a second request is not taken and lost
          idle <= 1'b0;
        end else if (write_req) begin
          wdata <= {3'h0, write_offset};
          w_oe <= 1'b1;
          cs_n <= 1'b0;
          wr_n <= 1'b0;
          cnt <= 5'h0_0;
          state <= ADCPPH_WRITE;
          idle <= 1'b0;
        end
        ADCPPH_TRIG: begin
          if (!busy_sync[1]) seen_low <= 1'b1;
          if (cnt == 5'(adcpp_pkg::STROBE_CYCLES)) begin
            trig_n <= 1'b1;
            state <= ADCPPH_WAIT;
          end else cnt <= cnt + 5'h0_1;
        end
        ADCPPH_WAIT: begin
          if (!busy_sync[1]) seen_low <= 1'b1;
          if (busy_rose) begin
            cs_n <= 1'b0;
            rd_n <= 1'b0;
            cnt <= 5'h0_0;
            state <= ADCPPH_READ;
          end
        end
        ADCPPH_READ: begin
          // Wait for the device's pin synchroniser and output register
          if (cnt == 5'(adcpp_pkg::STROBE_CYCLES + 3)) begin
            result_data <= port.data_bus;
            result_valid <= 1'b1;
            cs_n <= 1'b1;
            rd_n <= 1'b1;
            cnt <= 5'h0_0;
            state <= ADCPPH_QUIET;
          end else cnt <= cnt + 5'h0_1;
        end
        ADCPPH_WRITE: begin
          if (cnt == 5'(adcpp_pkg::STROBE_CYCLES + 2)) begin
            wr_n <= 1'b1;
            cnt <= 5'h0_0;
            state <= ADCPPH_QUIET;
          end else cnt <= cnt + 5'h0_1;
        end
        ADCPPH_QUIET: begin
          // Data stays driven through the quiet gap so the device captures it
          if (cnt == 5'(adcpp_pkg::QUIET_CYCLES + 3)) begin
            cs_n <= 1'b1;
            w_oe <= 1'b0;
            state <= ADCPPH_IDLE;
          end else cnt <= cnt + 5'h0_1;
        end
      endcase
    end
  end
  assign port.sample_trigger_n = trig_n;
  assign port.chip_select_n = cs_n;
  assign port.read_strobe_n = rd_n;
  assign port.write_strobe_n = wr_n;
  assign port.host_data_out = wdata;
  assign port.host_data_oe = w_oe;
endmodule : adcpp_host

/* File: tb/adcpp_props.sv */
/* Port wire checks.
   Assumes one clock; sits beside the interface. */
`timescale 1ns/1ps
module adcpp_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_trigger_n,
  input wire logic busy_n,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [12:0] dev_data_out,
  input wire logic dev_data_oe,
  input wire logic [12:0] data_bus
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd_on = !chip_select_n && !read_strobe_n;
  // Sync delay is 3 cycles; 4 allows the release tail
  oe_cause_a: assert property (dev_data_oe |-> $past(rd_on, 3) || $past(rd_on, 4))
    else $error("oe without read");
  oe_answer_a: assert property (rd_on [*5] |-> dev_data_oe)
    else $error("read not answered");
  busy_len_a: assert property ($fell(busy_n) |-> !busy_n [*8] ##1 !busy_n [*4] ##1 busy_n)
    else $error("bad conversion length");
  busy_cause_a: assert property ($fell(busy_n) |-> !$past(sample_trigger_n, 3) || !$past(sample_trigger_n, 4))
    else $error("busy without trigger");
  trig_taken_a: assert property ($fell(sample_trigger_n) && busy_n |-> ##[2:5] !busy_n)
    else $error("trigger ignored");
  conv_quiet_a: assert property (!busy_n |-> read_strobe_n && !dev_data_oe)
    else $error("read in conversion");
  quiet_gap_a: assert property ($fell(sample_trigger_n) |-> $past(read_strobe_n && write_strobe_n, 2))
    else $error("trigger too soon");
  ofs_top_a: assert property (!write_strobe_n && !chip_select_n |-> data_bus[12:10] == 3'h0)
    else $error("offset top bits set");
endmodule : adcpp_props

/* File: tb/adc_parallel_port_offset_overrange_tb.sv */
/* Bench: host and device joined by the port interface.
   Assumes the host end sequences each bus cycle. */
`timescale 1ns/1ps
module adc_parallel_port_offset_overrange_tb;
  logic clk;
  logic rst_n;
  logic saturate_select;
  logic [1:0] mode_pins;
  logic [11:0] raw_result;
  logic start_conv;
  logic write_req;
  logic [9:0] write_offset;
  logic mode_invalid;
  logic idle;
  logic result_valid;
  logic [12:0] result_data;
  logic [12:0] prev;
  int n_errors;
  int num_checks;
  logic [9:0] ofs_tab [5] = '{10'h380, 10'h000, 10'h100, 10'h147, 10'h2b9};
  logic [11:0] raw_tab [3] = '{12'h000, 12'h080, 12'hfff};
  adcpp_if adcpp_if_inst ();
  adcpp_device adcpp_device_inst (.clk(clk), .rst_n(rst_n), .saturate_select(saturate_select),
    .mode_pins(mode_pins), .raw_result(raw_result), .mode_invalid(mode_invalid), .port(adcpp_if_inst));
  adcpp_host adcpp_host_inst (.clk(clk), .rst_n(rst_n), .start_conv(start_conv), .write_req(write_req),
    .write_offset(write_offset), .idle(idle), .result_valid(result_valid), .result_data(result_data),
    .port(adcpp_if_inst));
  adcpp_props adcpp_props_inst (.clk(clk), .rst_n(rst_n), .sample_trigger_n(adcpp_if_inst.sample_trigger_n),
    .busy_n(adcpp_if_inst.busy_n), .chip_select_n(adcpp_if_inst.chip_select_n),
    .read_strobe_n(adcpp_if_inst.read_strobe_n), .write_strobe_n(adcpp_if_inst.write_strobe_n),
    .dev_data_out(adcpp_if_inst.dev_data_out), .dev_data_oe(adcpp_if_inst.dev_data_oe),
    .data_bus(adcpp_if_inst.data_bus));
  task automatic give_verdict;
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Bounded, so a dead handshake ends the run
  task automatic wait_for(input bit want_valid);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while ((want_valid ? result_valid : idle) !== 1'b1 && i < 300);
    if (i >= 300) begin
      n_errors++;
      give_verdict();
    end
  endtask : wait_for
  // Sum in 14 bits so clamp decisions see the true sign
  function automatic logic [12:0] calc(input logic [11:0] r, input logic [9:0] o, input logic s);
    logic signed [13:0] v;
    v = $signed({2'b00, r}) + $signed({{4{o[9]}}, o});
    if (!s) return v[12:0];
    if (v < 0) return 13'h1000;
    if (v > $signed({1'b0, adcpp_pkg::FULL_SCALE})) return 13'h1fff;
    return v[12:0];
  endfunction : calc
  task automatic conv(input logic [11:0] r, input logic [12:0] e);
    wait_for(1'b0);
    raw_result <= r;
    start_conv <= 1'b1;
    @(posedge clk);
    start_conv <= 1'b0;
    wait_for(1'b1);
    chk("result_data", e, result_data);
  endtask : conv
  task automatic put_ofs(input logic [9:0] o);
    wait_for(1'b0);
    write_offset <= o;
    write_req <= 1'b1;
    @(posedge clk);
    write_req <= 1'b0;
  endtask : put_ofs
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    saturate_select = 1'b0;
    mode_pins = adcpp_pkg::MODE_EARLY;
    raw_result = 12'h000;
    start_conv = 1'b0;
    write_req = 1'b0;
    write_offset = 10'h000;
    n_errors = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    conv(12'h123, 13'h0123);
    foreach (ofs_tab[k]) begin
      put_ofs(ofs_tab[k]);
      for (int s = 0; s < 2; s++) begin
        saturate_select <= s[0];
        foreach (raw_tab[j]) begin
          prev = calc(raw_tab[j], ofs_tab[k], s[0]);
          conv(raw_tab[j], prev);
        end
      end
    end
    mode_pins <= adcpp_pkg::MODE_DEFERRED;
    conv(12'h456, prev);
    conv(12'h789, calc(12'h456, 10'h2b9, 1'b1));
    mode_pins <= 2'h0;
    repeat (4) @(posedge clk);
    chk("mode_invalid", 13'h0001, {12'h000, mode_invalid});
    mode_pins <= 2'h3;
    repeat (4) @(posedge clk);
    chk("mode_invalid", 13'h0001, {12'h000, mode_invalid});
    mode_pins <= adcpp_pkg::MODE_EARLY;
    repeat (4) @(posedge clk);
    chk("mode_invalid", 13'h0000, {12'h000, mode_invalid});
    give_verdict();
  end
endmodule : adc_parallel_port_offset_overrange_tb
